// ==== core/nhc_addr_fmt.sv ====
`timescale 1ns/1ps

// Places one address cycle of a 30-bit word address onto the 16-bit bus.
module nhc_addr_fmt (
   input  wire logic [29:0] addr_in,
   input  wire logic [2:0]  cyc_in,
   output logic      [15:0] bus_out
);

   // ----------------------------------------------------------------
   // Cycle mapping
   // ----------------------------------------------------------------
   // Unused positions, the whole upper byte included, stay low.
   always_comb begin
      unique case (cyc_in)
         3'h0:    bus_out = {8'h00, addr_in[7:0]};
         3'h1:    bus_out = {13'h0000, addr_in[10:8]};
         3'h2:    bus_out = {8'h00, addr_in[18:11]};
         3'h3:    bus_out = {8'h00, addr_in[26:19]};
         3'h4:    bus_out = {13'h0000, addr_in[29:27]};
         default: bus_out = 16'h0000;
      endcase
   end

endmodule

// ==== core/nhc_host.sv ====
`timescale 1ns/1ps

// What this block does
// - Address cycles one and two carry column bits 0 to 10, low first.
// - Cycles three to five carry row bits 11 to 29, last holds three.
// - Host drives every unused address bit low, upper byte included.
// - No new command across dies until the running operation ends.
// - Host issues only command codes from the defined set.
// - Random column moves stay inside the currently addressed page.
// - Copy-back source and destination stay in the same plane.
// - Page read is 00h, five address cycles, then confirm 30h.
// - After status polling, reissue 00h before reading page data.
module nhc_host (
   input  wire logic        clock_in,
   input  wire logic        sys_rst_in,
   input  wire logic        req_valid_in,
   input  wire logic [3:0]  req_op_in,
   input  wire logic [29:0] req_addr_in,
   input  wire logic [29:0] req_addr2_in,
   input  wire logic [10:0] req_len_in,
   input  wire logic        allow_write_in,
   input  wire logic [15:0] io_in,
   input  wire logic        ready_busy_n_in,
   output logic             req_ready_out,
   output logic [15:0]      rd_data_out,
   output logic             rd_valid_out,
   output logic             done_out,
   output logic             err_out,
   output logic             ce_n_out,
   output logic             cle_out,
   output logic             ale_out,
   output logic             we_n_out,
   output logic             read_strobe_n_out,
   output logic             wp_n_out,
   output logic [15:0]      io_out,
   output logic             io_oe_out
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [15:0] io_s1_r;
   logic [15:0] io_s2_r;
   logic        rb_s1_r;
   logic        rb_s2_r;

   // Two flops before anything looks at the pins.
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         io_s1_r <= 16'h0000;
         io_s2_r <= 16'h0000;
         rb_s1_r <= 1'b0;
         rb_s2_r <= 1'b0;
      end else begin
         io_s1_r <= io_in;
         io_s2_r <= io_s1_r;
         rb_s1_r <= ready_busy_n_in;
         rb_s2_r <= rb_s1_r;
      end
   end

   // ----------------------------------------------------------------
   // Operation sequences
   // ----------------------------------------------------------------
   typedef enum {
      S_IDLE,
      S_STEP,
      S_WLO,
      S_WHI,
      S_WB,
      S_RDY,
      S_RLO,
      S_RHI
   } nhc_state_t;

   localparam logic [10:0] S_A5  = {nhc_pkg::K_ADR5, 8'h00};
   localparam logic [10:0] S_A5B = {nhc_pkg::K_ADR5B, 8'h00};
   localparam logic [10:0] S_A3  = {nhc_pkg::K_ADR3, 8'h00};
   localparam logic [10:0] S_A3B = {nhc_pkg::K_ADR3B, 8'h00};
   localparam logic [10:0] S_WT  = {nhc_pkg::K_WAIT, 8'h00};
   localparam logic [10:0] S_RD  = {nhc_pkg::K_READ, 8'h00};
   localparam logic [10:0] S_RD1 = {nhc_pkg::K_READ, 8'h01};
   localparam logic [10:0] S_EN  = {nhc_pkg::K_END, 8'h00};

   function automatic logic [10:0] cm(input logic [7:0] code);
      cm = {nhc_pkg::K_CMD, code};
   endfunction

   // Returns step idx of an operation; only defined codes ever reach the pins.
   function automatic logic [10:0] step_of(input nhc_pkg::nhc_op_t op,
                                           input logic [3:0] idx);
      logic [0:8][10:0] t;
      t = '{S_EN, S_EN, S_EN, S_EN, S_EN, S_EN, S_EN, S_EN, S_EN};
      unique case (op)
         nhc_pkg::OP_PAGE_READ:     t = '{cm(nhc_pkg::CMD_READ), S_A5,
            cm(nhc_pkg::CMD_READ_CONF), S_WT, S_RD, S_EN, S_EN, S_EN, S_EN};
         nhc_pkg::OP_CB_READ2:      t = '{cm(nhc_pkg::CMD_READ), S_A5,
            cm(nhc_pkg::CMD_READ), S_A5B, cm(nhc_pkg::CMD_CBRD_CONF), S_WT, S_EN, S_EN, S_EN};
         nhc_pkg::OP_CB_PROG:       t = '{cm(nhc_pkg::CMD_CB_PROG), S_A5,
            cm(nhc_pkg::CMD_PROG_CONF), S_WT, S_EN, S_EN, S_EN, S_EN, S_EN};
         nhc_pkg::OP_CB_PROG2_TRAD: t = '{cm(nhc_pkg::CMD_CB_PROG), S_A5,
            cm(nhc_pkg::CMD_PLANE_NEXT), S_WT, cm(nhc_pkg::CMD_PROG_TRAD2), S_A5B,
            cm(nhc_pkg::CMD_PROG_CONF), S_WT, S_EN};
         nhc_pkg::OP_CB_PROG2_ALT:  t = '{cm(nhc_pkg::CMD_CB_PROG), S_A5,
            cm(nhc_pkg::CMD_PLANE_NEXT), S_WT, cm(nhc_pkg::CMD_CB_PROG), S_A5B,
            cm(nhc_pkg::CMD_PROG_CONF), S_WT, S_EN};
         nhc_pkg::OP_ERASE2_TRAD:   t = '{cm(nhc_pkg::CMD_ERASE), S_A3,
            cm(nhc_pkg::CMD_ERASE), S_A3B, cm(nhc_pkg::CMD_ERASE_CONF), S_WT, S_EN, S_EN, S_EN};
         nhc_pkg::OP_ERASE2_ALT:    t = '{cm(nhc_pkg::CMD_ERASE), S_A3,
            cm(nhc_pkg::CMD_ERASE_NEXT), cm(nhc_pkg::CMD_ERASE), S_A3B,
            cm(nhc_pkg::CMD_ERASE_CONF), S_WT, S_EN, S_EN};
         nhc_pkg::OP_PLANE_READ:    t = '{cm(nhc_pkg::CMD_PLANE_RD), S_A5,
            cm(nhc_pkg::CMD_COL_CONF), S_WT, S_RD, S_EN, S_EN, S_EN, S_EN};
         nhc_pkg::OP_STATUS:        t = '{cm(nhc_pkg::CMD_STATUS), S_WT, S_RD1,
            S_EN, S_EN, S_EN, S_EN, S_EN, S_EN};
         nhc_pkg::OP_RESUME_READ:   t = '{cm(nhc_pkg::CMD_READ), S_WT, S_RD,
            S_EN, S_EN, S_EN, S_EN, S_EN, S_EN};
         default:                   t = '{S_EN, S_EN, S_EN, S_EN, S_EN, S_EN, S_EN, S_EN, S_EN};
      endcase
      step_of = (idx > 4'h8) ? S_EN : t[idx];
   endfunction

   // ----------------------------------------------------------------
   // Sequencer state
   // ----------------------------------------------------------------
   nhc_state_t        st_r, st_nxt;
   nhc_pkg::nhc_op_t  op_r, op_nxt;
   logic [7:0]        tmr_r, tmr_nxt;
   logic [3:0]        idx_r, idx_nxt;
   logic [2:0]        acyc_r, acyc_nxt;
   logic [10:0]       cnt_r, cnt_nxt;
   logic [29:0]       addr_r, addr_nxt;
   logic [29:0]       addr2_r, addr2_nxt;
   logic              src_pl_r, src_pl_nxt;
   logic              src_pl2_r, src_pl2_nxt;
   logic              ce_n_r, ce_n_nxt, cle_r, cle_nxt, ale_r, ale_nxt;
   logic              we_n_r, we_n_nxt, re_n_r, re_n_nxt, oe_r, oe_nxt;
   logic              rdy_r, rdy_nxt, dv_r, dv_nxt, done_r, done_nxt;
   logic              err_r, err_nxt, wp_n_r;
   logic [15:0]       io_r, io_nxt, dat_r, dat_nxt;
   logic [10:0]       step;
   nhc_pkg::nhc_kind_t kind;
   logic              adr3, adr_b, last_acyc;
   logic [2:0]        fmt_cyc;
   logic [15:0]       fmt_bus;
   logic [10:0]       room;
   logic              pl_bad;
   nhc_pkg::nhc_op_t  req_op;

   assign step      = step_of(op_r, idx_r);
   assign kind      = nhc_pkg::nhc_kind_t'(step[10:8]);
   assign adr3      = (kind == nhc_pkg::K_ADR3) || (kind == nhc_pkg::K_ADR3B);
   assign adr_b     = (kind == nhc_pkg::K_ADR5B) || (kind == nhc_pkg::K_ADR3B);
   assign fmt_cyc   = adr3 ? 3'(acyc_r + nhc_pkg::ROW_CYC) : acyc_r;
   assign last_acyc = (fmt_cyc == nhc_pkg::LAST_CYC);
   assign room      = nhc_pkg::PAGE_WORDS - addr_r[10:0];
   assign req_op    = nhc_pkg::nhc_op_t'(req_op_in);

   // Copy-back program must land in the plane(s) the data was read from.
   assign pl_bad = ((req_op == nhc_pkg::OP_CB_PROG) || (req_op == nhc_pkg::OP_CB_PROG2_TRAD) ||
                    (req_op == nhc_pkg::OP_CB_PROG2_ALT)) &&
                   ((req_addr_in[nhc_pkg::PLANE_BIT] != src_pl_r) ||
                    ((req_op != nhc_pkg::OP_CB_PROG) &&
                     (req_addr2_in[nhc_pkg::PLANE_BIT] != src_pl2_r)));

   nhc_addr_fmt u_fmt (
      .addr_in (adr_b ? addr2_r : addr_r),
      .cyc_in  (fmt_cyc),
      .bus_out (fmt_bus)
   );

   // Next-state logic of the sequencer and of every pin but write protect.
   always_comb begin
      st_nxt = st_r; op_nxt = op_r; tmr_nxt = tmr_r; idx_nxt = idx_r;
      acyc_nxt = acyc_r; cnt_nxt = cnt_r; addr_nxt = addr_r; addr2_nxt = addr2_r;
      src_pl_nxt = src_pl_r; src_pl2_nxt = src_pl2_r;
      ce_n_nxt = ce_n_r; cle_nxt = cle_r; ale_nxt = ale_r; we_n_nxt = we_n_r;
      re_n_nxt = re_n_r; oe_nxt = oe_r; io_nxt = io_r; dat_nxt = dat_r;
      rdy_nxt = rdy_r; dv_nxt = 1'b0; done_nxt = 1'b0; err_nxt = 1'b0;
      tmr_nxt = (tmr_r > 8'h01) ? 8'(tmr_r - 8'h01) : tmr_r;
      unique case (st_r)
         S_IDLE: begin
            if (req_valid_in && rdy_r) begin
               if ((req_op_in >= nhc_pkg::OP_COUNT) || pl_bad) begin
                  err_nxt  = 1'b1;
                  done_nxt = 1'b1;
               end else begin
                  op_nxt   = req_op;
                  addr_nxt = req_addr_in;
                  addr2_nxt = req_addr2_in;
                  idx_nxt  = 4'h0;
                  acyc_nxt = 3'h0;
                  rdy_nxt  = 1'b0;
                  ce_n_nxt = 1'b0;
                  st_nxt   = S_STEP;
                  if (req_op == nhc_pkg::OP_CB_READ2) begin
                     src_pl_nxt  = req_addr_in[nhc_pkg::PLANE_BIT];
                     src_pl2_nxt = req_addr2_in[nhc_pkg::PLANE_BIT];
                  end
               end
            end
         end
         S_STEP: begin
            unique case (kind)
               nhc_pkg::K_CMD: begin
                  io_nxt = {8'h00, step[7:0]};
                  cle_nxt = 1'b1; ale_nxt = 1'b0; oe_nxt = 1'b1; re_n_nxt = 1'b1;
                  we_n_nxt = 1'b0; tmr_nxt = nhc_pkg::WP_CYC; st_nxt = S_WLO;
               end
               nhc_pkg::K_ADR5, nhc_pkg::K_ADR5B, nhc_pkg::K_ADR3, nhc_pkg::K_ADR3B: begin
                  io_nxt = fmt_bus;
                  cle_nxt = 1'b0; ale_nxt = 1'b1; oe_nxt = 1'b1; re_n_nxt = 1'b1;
                  we_n_nxt = 1'b0; tmr_nxt = nhc_pkg::WP_CYC; st_nxt = S_WLO;
               end
               nhc_pkg::K_WAIT: begin
                  cle_nxt = 1'b0; ale_nxt = 1'b0; oe_nxt = 1'b0;
                  tmr_nxt = nhc_pkg::WB_CYC; st_nxt = S_WB;
               end
               nhc_pkg::K_READ: begin
                  // Word count clamps at page end; zero asks for the rest.
                  if (step[7:0] != 8'h00)
                     cnt_nxt = 11'h001;
                  else if ((req_len_in == 11'h000) || (req_len_in > room))
                     cnt_nxt = room;
                  else
                     cnt_nxt = req_len_in;
                  cle_nxt = 1'b0; ale_nxt = 1'b0; oe_nxt = 1'b0;
                  re_n_nxt = 1'b0; tmr_nxt = nhc_pkg::RP_CYC; st_nxt = S_RLO;
               end
               default: begin
                  ce_n_nxt = 1'b1; cle_nxt = 1'b0; ale_nxt = 1'b0; oe_nxt = 1'b0;
                  re_n_nxt = 1'b1; done_nxt = 1'b1; rdy_nxt = 1'b1; st_nxt = S_IDLE;
               end
            endcase
         end
         S_WLO: begin
            if (tmr_r == 8'h01) begin
               we_n_nxt = 1'b1;
               tmr_nxt  = nhc_pkg::WH_CYC;
               st_nxt   = S_WHI;
            end
         end
         S_WHI: begin
            if (tmr_r == 8'h01) begin
               st_nxt = S_STEP;
               if ((kind != nhc_pkg::K_CMD) && !last_acyc) begin
                  acyc_nxt = 3'(acyc_r + 3'h1);
               end else begin
                  acyc_nxt = 3'h0;
                  idx_nxt  = 4'(idx_r + 4'h1);
               end
            end
         end
         S_WB: begin
            if (tmr_r == 8'h01)
               st_nxt = S_RDY;
         end
         S_RDY: begin
            // Nothing more is sent until the device reports ready.
            if (rb_s2_r) begin
               idx_nxt = 4'(idx_r + 4'h1);
               st_nxt  = S_STEP;
            end
         end
         S_RLO: begin
            if (tmr_r == 8'h01) begin
               dat_nxt  = io_s2_r;
               dv_nxt   = 1'b1;
               re_n_nxt = 1'b1;
               tmr_nxt  = nhc_pkg::REH_CYC;
               st_nxt   = S_RHI;
            end
         end
         S_RHI: begin
            if (tmr_r == 8'h01) begin
               cnt_nxt = 11'(cnt_r - 11'h001);
               if (cnt_r == 11'h001) begin
                  idx_nxt = 4'(idx_r + 4'h1);
                  st_nxt  = S_STEP;
               end else begin
                  re_n_nxt = 1'b0;
                  tmr_nxt  = nhc_pkg::RP_CYC;
                  st_nxt   = S_RLO;
               end
            end
         end
      endcase
   end

   // Registers of the sequencer; every pin and status output is a flop.
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         st_r <= S_IDLE; op_r <= nhc_pkg::OP_PAGE_READ; tmr_r <= 8'h00;
         idx_r <= 4'h0; acyc_r <= 3'h0; cnt_r <= 11'h000;
         addr_r <= 30'h00000000; addr2_r <= 30'h00000000;
         src_pl_r <= 1'b0; src_pl2_r <= 1'b0;
         ce_n_r <= 1'b1; cle_r <= 1'b0; ale_r <= 1'b0; we_n_r <= 1'b1;
         re_n_r <= 1'b1; oe_r <= 1'b0; io_r <= 16'h0000; dat_r <= 16'h0000;
         rdy_r <= 1'b1; dv_r <= 1'b0; done_r <= 1'b0; err_r <= 1'b0; wp_n_r <= 1'b0;
      end else begin
         st_r <= st_nxt; op_r <= op_nxt; tmr_r <= tmr_nxt;
         idx_r <= idx_nxt; acyc_r <= acyc_nxt; cnt_r <= cnt_nxt;
         addr_r <= addr_nxt; addr2_r <= addr2_nxt;
         src_pl_r <= src_pl_nxt; src_pl2_r <= src_pl2_nxt;
         ce_n_r <= ce_n_nxt; cle_r <= cle_nxt; ale_r <= ale_nxt; we_n_r <= we_n_nxt;
         re_n_r <= re_n_nxt; oe_r <= oe_nxt; io_r <= io_nxt; dat_r <= dat_nxt;
         rdy_r <= rdy_nxt; dv_r <= dv_nxt; done_r <= done_nxt; err_r <= err_nxt;
         wp_n_r <= allow_write_in;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign req_ready_out     = rdy_r;
   assign rd_data_out       = dat_r;
   assign rd_valid_out      = dv_r;
   assign done_out          = done_r;
   assign err_out           = err_r;
   assign ce_n_out          = ce_n_r;
   assign cle_out           = cle_r;
   assign ale_out           = ale_r;
   assign we_n_out          = we_n_r;
   assign read_strobe_n_out = re_n_r;
   assign wp_n_out          = wp_n_r;
   assign io_out            = io_r;
   assign io_oe_out         = oe_r;

endmodule

// ==== core/nhc_pkg.sv ====
package nhc_pkg;

   // ----------------------------------------------------------------
   // Clock and pin timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned T_WP_NS       = 25;   // Write strobe low time.
   localparam int unsigned T_WH_NS       = 15;   // Write strobe high time.
   localparam int unsigned T_RP_NS       = 25;   // Read strobe low time.
   localparam int unsigned T_REH_NS      = 15;   // Read strobe high time.
   localparam int unsigned T_WB_NS       = 100;  // Strobe to busy, also covers turnaround.
   localparam int unsigned SYNC_STAGES   = 2;

   // Least times round up to whole cycles, never below one.
   localparam logic [7:0] WP_CYC  = 8'((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] WH_CYC  = 8'((T_WH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] RP_CYC  = 8'((T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
                                       + SYNC_STAGES);
   localparam logic [7:0] REH_CYC = 8'((T_REH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] WB_CYC  = 8'((T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // ----------------------------------------------------------------
   // Command codes
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_READ       = 8'h00;
   localparam logic [7:0] CMD_READ_CONF  = 8'h30;
   localparam logic [7:0] CMD_CBRD_CONF  = 8'h35;
   localparam logic [7:0] CMD_STATUS     = 8'h70;
   localparam logic [7:0] CMD_CB_PROG    = 8'h85;
   localparam logic [7:0] CMD_PROG_CONF  = 8'h10;
   localparam logic [7:0] CMD_PLANE_NEXT = 8'h11;
   localparam logic [7:0] CMD_PROG_TRAD2 = 8'h81;
   localparam logic [7:0] CMD_ERASE      = 8'h60;
   localparam logic [7:0] CMD_ERASE_CONF = 8'hd0;
   localparam logic [7:0] CMD_ERASE_NEXT = 8'hd1;
   localparam logic [7:0] CMD_PLANE_RD   = 8'h06;
   localparam logic [7:0] CMD_COL_CONF   = 8'he0;

   // ----------------------------------------------------------------
   // Address layout of the 16-bit organisation
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W     = 30;
   localparam int unsigned COL_W      = 11;
   localparam int unsigned PLANE_BIT  = 17;
   localparam logic [10:0] PAGE_WORDS = 11'h420;
   localparam logic [2:0]  LAST_CYC   = 3'h4;
   localparam logic [2:0]  ROW_CYC    = 3'h2;

   // ----------------------------------------------------------------
   // Host operations and sequence step kinds
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_PAGE_READ,
      OP_CB_READ2,
      OP_CB_PROG,
      OP_CB_PROG2_TRAD,
      OP_CB_PROG2_ALT,
      OP_ERASE2_TRAD,
      OP_ERASE2_ALT,
      OP_PLANE_READ,
      OP_STATUS,
      OP_RESUME_READ
   } nhc_op_t;

   localparam logic [3:0] OP_COUNT = 4'ha;

   typedef enum logic [2:0] {
      K_CMD,
      K_ADR5,
      K_ADR5B,
      K_ADR3,
      K_ADR3B,
      K_WAIT,
      K_READ,
      K_END
   } nhc_kind_t;

endpackage

// ==== tb/nhc_flash_model.sv ====
`timescale 1ns/1ps

// Behavioural flash die: latches commands and addresses, holds the pull-down
// through the array load and streams words out of its data register.
module nhc_flash_model (
   input  wire logic        ce_n_in,
   input  wire logic        cle_in,
   input  wire logic        ale_in,
   input  wire logic        we_n_in,
   input  wire logic        re_n_in,
   input  wire logic        wp_n_in,
   input  wire logic [15:0] io_in,
   output logic      [15:0] io_out,
   output logic             busy_out
);
   logic [7:0]  last_cmd = 8'h00;  // Read already latched at power-up.
   logic [39:0] adr      = 40'h0;
   logic [2:0]  n_adr    = 3'h0;
   logic [10:0] col      = 11'h0;
   int          n_we     = 0;

   // Idle levels at time zero.
   initial begin
      io_out = 16'h0;
      busy_out = 1'b0;
   end

   // Commands and address cycles are taken on the write strobe rise.
   always @(posedge we_n_in) begin
      if (!ce_n_in) begin
         n_we = n_we + 1;
         if (cle_in) begin
            last_cmd = io_in[7:0];
            n_adr = 3'h0;
            if (io_in[7:0] == 8'h30 || io_in[7:0] == 8'h35 ||
                (wp_n_in && (io_in[7:0] == 8'h10 || io_in[7:0] == 8'hd0))) begin
               // Array work holds the pin low.
               busy_out <= 1'b1;
               busy_out <= #300 1'b0;
            end
         end else if (ale_in && n_adr < 3'h5) begin
            adr[8*n_adr +: 8] = io_in[7:0];
            n_adr = n_adr + 3'h1;
            col = adr[10:0];
         end
      end
   end

   // A strobe fall shows status after 70h, else the word at the column.
   always @(negedge re_n_in) begin
      if (!ce_n_in && last_cmd == 8'h70)
         io_out <= #10 {8'h00, wp_n_in, ~busy_out, 6'h20};
      else if (!ce_n_in)
         io_out <= #10 {adr[22], 4'ha, col};
   end

   // The column steps on the rise except after 70h; the released bus never keeps the word.
   always @(posedge re_n_in) begin
      if (last_cmd != 8'h70)
         col = col + 11'h1;
      io_out <= ~io_out;
   end
endmodule

// ==== tb/nhc_host_checker.sv ====
`timescale 1ns/1ps

// Watches the host pins and request port for protocol slips.
module nhc_host_checker (
   input  wire logic        clock_in,
   input  wire logic        sys_rst_in,
   input  wire logic        req_valid_in,
   input  wire logic [3:0]  req_op_in,
   input  wire logic        ready_busy_n_in,
   input  wire logic        req_ready_out,
   input  wire logic        rd_valid_out,
   input  wire logic        done_out,
   input  wire logic        err_out,
   input  wire logic        ce_n_out,
   input  wire logic        cle_out,
   input  wire logic        ale_out,
   input  wire logic        we_n_out,
   input  wire logic        read_strobe_n_out,
   input  wire logic [15:0] io_out,
   input  wire logic        io_oe_out
);
   default clocking chk_cb @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);

   // Pin protocol around the strobes.
   upper_byte_a: assert property (ale_out && io_oe_out |-> io_out[15:8] == 8'h00)
      else $error("upper byte driven in address cycle");
   latch_hold_a: assert property ($rose(we_n_out) |-> $stable(cle_out) && $stable(ale_out)
      && $stable(io_out)) else $error("latch inputs moved at strobe rise");
   read_quiet_a: assert property (!read_strobe_n_out |-> !cle_out && !ale_out
      && !io_oe_out && !ce_n_out) else $error("bad pins during read strobe");
   write_quiet_a: assert property (!we_n_out |-> read_strobe_n_out && !ce_n_out
      && io_oe_out) else $error("bad pins during write strobe");
   busy_hold_a: assert property (!ready_busy_n_in [*3] |-> we_n_out && read_strobe_n_out)
      else $error("strobe while device busy");

   // Request port behaviour.
   refuse_op_a: assert property (req_valid_in && req_ready_out && req_op_in >= 4'ha
      |=> done_out && err_out) else $error("bad op code not refused");
   take_busy_a: assert property (req_valid_in && req_ready_out && req_op_in < 4'h2
      |=> !req_ready_out && !done_out) else $error("read not started");
   rd_edge_a: assert property (rd_valid_out |-> $rose(read_strobe_n_out))
      else $error("word without strobe rise");

   cover property (done_out && err_out);
   cover property (rd_valid_out);
   cover property (!ready_busy_n_in);
endmodule

bind nhc_host nhc_host_checker u_chk (.*);

// ==== tb/testbench.sv ====
`timescale 1ns/1ps

// Drives the host through every operation against the flash model.
module testbench;
   typedef struct packed {
      logic [3:0] op; logic [29:0] a; logic [10:0] len; int nw;
      logic [15:0] w0; logic err; int nwe; logic [7:0] lc;
   } nhc_row_t;
   logic        clock_in = 1'b0;
   logic        sys_rst_in = 1'b1;
   logic        req_valid_in = 1'b0;
   logic [3:0]  req_op_in = 4'h0;
   logic [29:0] req_addr_in = 30'h0;
   logic [10:0] req_len_in = 11'h0;
   logic        allow_write_in = 1'b1;
   logic [15:0] dev_io, rd_data_out, io_out;
   logic        dev_busy, req_ready_out, rd_valid_out, done_out, err_out, ce_n_out;
   logic        cle_out, ale_out, we_n_out, read_strobe_n_out, wp_n_out, io_oe_out, got_err;
   logic [29:0] req_addr2_in = 30'h20000;
   wire  [15:0] io_in = io_oe_out ? io_out : dev_io;
   wire         ready_busy_n_in = ~dev_busy;  // Open drain with pull-up.
   logic [15:0] got[$];
   int          fail_count = 0;
   int          checks = 0;
   nhc_row_t    rows[13];

   nhc_host DUT (.*);
   nhc_flash_model flash (.ce_n_in(ce_n_out), .cle_in(cle_out), .ale_in(ale_out),
      .we_n_in(we_n_out), .re_n_in(read_strobe_n_out), .wp_n_in(wp_n_out),
      .io_in(io_out), .io_out(dev_io), .busy_out(dev_busy));

   // Clock at 200 MHz.
   always #2.5 clock_in = ~clock_in;

   // Compares and counts.
   task automatic check(input string name, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Prints the verdict and ends the run.
   task automatic stop_test;
      if (fail_count == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Issues one request and gathers words until the done pulse.
   task automatic run_op(input logic [3:0] op, input logic [29:0] a, input logic [10:0] len);
      int n;
      n = 0;
      got.delete();
      req_op_in = op;
      req_addr_in = a;
      req_len_in = len;
      req_valid_in = 1'b1;
      @(negedge clock_in);
      req_valid_in = 1'b0;
      while (done_out !== 1'b1 && n < 20000) begin
         @(negedge clock_in);
         n++;
         if (rd_valid_out === 1'b1) got.push_back(rd_data_out);
      end
      got_err = err_out;
      if (n >= 20000) fail_count++;
      // One idle edge keeps back-to-back requests from rewriting the strobe at once.
      @(negedge clock_in);
   endtask

   // Table of operations, then write protect and reset in mid-run.
   initial begin
      int base;
      rows = '{'{4'h0, 30'h5, 11'h3, 3, 16'h5005, 1'b0, 7, 8'h30},
               '{4'h8, 30'h0, 11'h0, 1, 16'h00e0, 1'b0, 1, 8'h70},
               '{4'h9, 30'h0, 11'h2, 2, 16'h5008, 1'b0, 1, 8'h00},
               '{4'h0, 30'h2041e, 11'h0, 2, 16'hd41e, 1'b0, 7, 8'h30},
               '{4'h7, 30'h20003, 11'h2, 2, 16'hd003, 1'b0, 7, 8'he0},
               '{4'h1, 30'h0, 11'h0, 0, 16'h0, 1'b0, 13, 8'h35},
               '{4'h2, 30'h0, 11'h0, 0, 16'h0, 1'b0, 7, 8'h10},
               '{4'h3, 30'h0, 11'h0, 0, 16'h0, 1'b0, 14, 8'h10},
               '{4'h4, 30'h0, 11'h0, 0, 16'h0, 1'b0, 14, 8'h10},
               '{4'h5, 30'h0, 11'h0, 0, 16'h0, 1'b0, 9, 8'hd0},
               '{4'h6, 30'h0, 11'h0, 0, 16'h0, 1'b0, 10, 8'hd0},
               '{4'hf, 30'h0, 11'h0, 0, 16'h0, 1'b1, 0, 8'hd0},
               '{4'h2, 30'h20000, 11'h0, 0, 16'h0, 1'b1, 0, 8'hd0}};
      repeat (5) @(negedge clock_in);
      sys_rst_in = 1'b0;
      check("idle ready", req_ready_out, 1'b1);
      check("idle select", ce_n_out, 1'b1);
      for (int i = 0; i < 13; i++) begin
         base = flash.n_we;
         run_op(rows[i].op, rows[i].a, rows[i].len);
         check("refusal", got_err, rows[i].err);
         check("strobes", flash.n_we - base, rows[i].nwe);
         check("last command", flash.last_cmd, rows[i].lc);
         check("word count", got.size(), rows[i].nw);
         foreach (got[k]) check("word", got[k], rows[i].w0 + 16'(k));
      end
      // A second-plane target outside the remembered source plane is refused.
      req_addr2_in = 30'h0;
      run_op(4'h3, 30'h0, 11'h0);
      check("second plane refusal", got_err, 1'b1);
      allow_write_in = 1'b0;
      repeat (2) @(negedge clock_in);
      check("protect pin", wp_n_out, 1'b0);
      run_op(4'h5, 30'h0, 11'h0);
      run_op(4'h8, 30'h0, 11'h0);
      check("protected status", got[0], 16'h0060);
      allow_write_in = 1'b1;
      req_op_in = 4'h0;
      req_valid_in = 1'b1;
      @(negedge clock_in);
      req_valid_in = 1'b0;
      repeat (30) @(negedge clock_in);
      sys_rst_in = 1'b1;
      @(negedge clock_in);
      check("reset select", ce_n_out, 1'b1);
      check("reset strobe", we_n_out, 1'b1);
      sys_rst_in = 1'b0;
      run_op(4'h0, 30'h41f, 11'h5);
      check("after reset", got[0], 16'h541f);
      check("page end clamp", got.size(), 1);
      stop_test();
   end

   // Cuts a hung run short.
   initial begin
      #300000;
      fail_count++;
      stop_test();
   end
endmodule
